// file: core/tfis_top.sv
// Interrupt status and enable logic of one receive T1 framer channel.
//
// Operation
// - Frame-mimic detection sets status bit 2.
// - CRC-6 multiframe error sets status bit 1.
// - One or more framing-bit errors set status bit 0.
// - Framing-bit error status is separate from frame alignment state.
// - Status bits are sticky, cleared by status read, reset to zero.
// - Any ABCD change in 24 channels raises signaling interrupt when enabled.
// - Signaling-change enable has no effect with robbed-bit signaling off.
// - Changed channels are recorded in signaling-change registers.
// - Apparent move of framing bits raises alignment-change interrupt.
// - Out-of-frame declare and clear both raise interrupt when enabled.
// - Frame-mimic enable gates frame-mimic interrupt.
// - Enable bits are read/write, one enables, reset to zero.
// - Out-of-frame declared on threshold errors within configured window.
// - Status bit 3 records out-of-frame change, both edges, clear on read.
`timescale 1ns/1ps
`default_nettype none
`include "tfis_consts.svh"
module tfis_top (
    input  wire logic                      clk_sys,
    input  wire logic                      rst,
    input  wire logic [`TFIS_ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]                reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic [7:0]                     reg_rdata,
    input  wire logic                      fbit_valid,
    input  wire logic                      fbit_error,
    input  wire logic                      crc6_error,
    input  wire logic                      frame_mimic,
    input  wire logic                      alignment_change,
    input  wire logic [`TFIS_NUM_CHAN-1:0] sig_change,
    output logic                           in_frame,
    output logic                           irq
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                status;
        logic [7:0]                enable;
        logic [3:0]                threshold;
        logic [3:0]                window;
        logic [7:0]                ctrl;
        logic [`TFIS_NUM_CHAN-1:0] sig_chg;
        logic [7:0]                rdata;
    } tfis_regs_t;

    tfis_regs_t   r_q;
    tfis_regs_t   r_d;
    logic [7:0]   ev;
    logic         rbs_on;
    logic [`TFIS_NUM_CHAN-1:0] sig_set;
    logic         rd_status;
    logic         rd_sig0;
    logic         rd_sig1;
    logic         rd_sig2;

    tfis_oof_if oof_bus ();

    // Checks that leave out their clock sample on the system clock and sleep in reset.
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------------
    // Out-of-frame detector
    // ------------------------------------------------------------------------
    assign oof_bus.error_threshold = r_q.threshold;
    assign oof_bus.error_window    = r_q.window;

    tfis_oof_detect u_oof (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .fbit_valid (fbit_valid),
        .fbit_error (fbit_error),
        .realign    (alignment_change),
        .oof        (oof_bus.det)
    );

    // ------------------------------------------------------------------------
    // Event vector
    // ------------------------------------------------------------------------
    // Robbed-bit signaling off suppresses signaling-change events entirely,
    // so a stale enable cannot raise a meaningless interrupt.
    assign rbs_on  = r_q.ctrl[`TFIS_BIT_RBS_EN];
    assign sig_set = rbs_on ? sig_change : '0;

    always_comb begin
        ev                 = 8'h00;
        ev[`TFIS_BIT_FE]   = fbit_valid && fbit_error;
        ev[`TFIS_BIT_SE]   = crc6_error;
        ev[`TFIS_BIT_FMD]  = frame_mimic;
        ev[`TFIS_BIT_OOF]  = oof_bus.declare || oof_bus.clear;
        ev[`TFIS_BIT_ALIGNMENT_CHANGE] = alignment_change;
        ev[`TFIS_BIT_SIG]  = |sig_set;
    end

    // ------------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------------
    always_comb begin
        rd_status = 1'b0;
        rd_sig0   = 1'b0;
        rd_sig1   = 1'b0;
        rd_sig2   = 1'b0;
        if (reg_rd && reg_addr == `TFIS_OFF_STATUS) begin
            rd_status = 1'b1;
        end else if (reg_rd && reg_addr == `TFIS_OFF_SIG_CHG0) begin
            rd_sig0 = 1'b1;
        end else if (reg_rd && reg_addr == `TFIS_OFF_SIG_CHG1) begin
            rd_sig1 = 1'b1;
        end else if (reg_rd && reg_addr == `TFIS_OFF_SIG_CHG2) begin
            rd_sig2 = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // A read clears the sticky bits, but an event in the same cycle is
    // OR-ed in afterwards so it is never lost.
    always_comb begin
        r_d = r_q;

        // Register writes.
        if (reg_wr && reg_addr == `TFIS_OFF_ENABLE) begin
            r_d.enable = {2'b00, reg_wdata[`TFIS_NUM_SRC-1:0]};
        end else if (reg_wr && reg_addr == `TFIS_OFF_OOF_CFG) begin
            r_d.threshold = reg_wdata[3:0];
            r_d.window    = reg_wdata[7:4];
        end else if (reg_wr && reg_addr == `TFIS_OFF_CTRL) begin
            r_d.ctrl = {7'h00, reg_wdata[`TFIS_BIT_RBS_EN]};
        end

        // Read data, captured for the following cycle.
        r_d.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr == `TFIS_OFF_STATUS) begin
                r_d.rdata = r_q.status;
            end else if (reg_addr == `TFIS_OFF_ENABLE) begin
                r_d.rdata = r_q.enable;
            end else if (reg_addr == `TFIS_OFF_OOF_CFG) begin
                r_d.rdata = {r_q.window, r_q.threshold};
            end else if (reg_addr == `TFIS_OFF_SIG_CHG0) begin
                r_d.rdata = r_q.sig_chg[7:0];
            end else if (reg_addr == `TFIS_OFF_SIG_CHG1) begin
                r_d.rdata = r_q.sig_chg[15:8];
            end else if (reg_addr == `TFIS_OFF_SIG_CHG2) begin
                r_d.rdata = r_q.sig_chg[23:16];
            end else if (reg_addr == `TFIS_OFF_CTRL) begin
                r_d.rdata = r_q.ctrl;
            end else if (reg_addr == `TFIS_OFF_ALIGN) begin
                r_d.rdata = {7'h00, oof_bus.in_frame};
            end
        end

        // Sticky status, clear on read, set wins.
        r_d.status = (rd_status ? 8'h00 : r_q.status) | ev;

        // Per-channel change record, each byte cleared by its own read.
        r_d.sig_chg = r_q.sig_chg;
        if (rd_sig0) begin
            r_d.sig_chg[7:0] = 8'h00;
        end
        if (rd_sig1) begin
            r_d.sig_chg[15:8] = 8'h00;
        end
        if (rd_sig2) begin
            r_d.sig_chg[23:16] = 8'h00;
        end
        r_d.sig_chg = r_d.sig_chg | sig_set;
    end

    // ------------------------------------------------------------------------
    // Register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            r_q <= '{status:    `TFIS_RST_STATUS,
                     enable:    `TFIS_RST_ENABLE,
                     threshold: `TFIS_RST_THRESH,
                     window:    `TFIS_RST_WINDOW,
                     ctrl:      `TFIS_RST_CTRL,
                     sig_chg:   '0,
                     rdata:     8'h00};
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Signaling enable is also qualified by robbed-bit mode for the line.
    assign reg_rdata = r_q.rdata;
    assign in_frame  = oof_bus.in_frame;
    assign irq = |(r_q.status & r_q.enable &
                   {2'b00, rbs_on, 5'h1f});

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    a_fe_sets: assert property (@(posedge clk_sys) disable iff (rst)
        (fbit_valid && fbit_error) |=> r_q.status[`TFIS_BIT_FE])
        else $error("framing error event did not set status");

    a_se_sets: assert property (@(posedge clk_sys) disable iff (rst)
        crc6_error |=> r_q.status[`TFIS_BIT_SE])
        else $error("crc6 event did not set status");

    a_fmd_sets: assert property (@(posedge clk_sys) disable iff (rst)
        frame_mimic |=> r_q.status[`TFIS_BIT_FMD])
        else $error("frame mimic event did not set status");

    a_read_clears: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_rd && reg_addr == `TFIS_OFF_STATUS && ev == 8'h00)
            |=> (r_q.status == 8'h00) && (reg_rdata == $past(r_q.status)))
        else $error("status read did not return and clear");

    a_oof_both: assert property (@(posedge clk_sys) disable iff (rst)
        $changed(oof_bus.in_frame) |-> r_q.status[`TFIS_BIT_OOF])
        else $error("out of frame change not recorded");

    a_sig_gated: assert property (@(posedge clk_sys) disable iff (rst)
        (!rbs_on && !$past(rbs_on) && !$past(r_q.status[`TFIS_BIT_SIG]))
            |-> !r_q.status[`TFIS_BIT_SIG])
        else $error("signaling status set with robbed bit off");

    a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
        (r_q.enable[`TFIS_BIT_ALIGNMENT_CHANGE] && alignment_change &&
         !(reg_wr && reg_addr == `TFIS_OFF_ENABLE)) |=> irq)
        else $error("enabled alignment change raised no interrupt");

    a_en_write: assert property (@(posedge clk_sys) disable iff (rst)
        (reg_wr && reg_addr == `TFIS_OFF_ENABLE)
            |=> r_q.enable[5:0] == $past(reg_wdata[5:0]))
        else $error("enable register write lost");

    a_irq_quiet: assert property (@(posedge clk_sys) disable iff (rst)
        (r_q.enable == 8'h00) |-> !irq)
        else $error("interrupt raised with all sources disabled");

    // Event capture and the per-channel change record.
    a_alignment_change_sets: assert property (
        alignment_change
            |=> r_q.status[`TFIS_BIT_ALIGNMENT_CHANGE])
        else $error("alignment change did not set status");

    a_sig_sets: assert property (
        (rbs_on && (|sig_change))
            |=> r_q.status[`TFIS_BIT_SIG])
        else $error("signaling change did not set status");

    a_sig_record: assert property (
        (|sig_set)
            |=> ((r_q.sig_chg & $past(sig_set)) == $past(sig_set)))
        else $error("changed channel not recorded");

    a_sig_rd_clear: assert property (
        (rd_sig0 && sig_set[7:0] == 8'h00)
            |=> (r_q.sig_chg[7:0] == 8'h00))
        else $error("change record byte not cleared by read");

    a_sig_keep: assert property (
        !(rd_sig0 || rd_sig1 || rd_sig2)
            |=> ((r_q.sig_chg & $past(r_q.sig_chg)) == $past(r_q.sig_chg)))
        else $error("change record lost without a read");

    a_status_keep: assert property (
        !rd_status
            |=> ((r_q.status & $past(r_q.status)) == $past(r_q.status)))
        else $error("status bit dropped without a read");

    a_rdata_idle: assert property (
        !reg_rd
            |=> (reg_rdata == 8'h00))
        else $error("read data not zero outside a read");

    // Out-of-frame detector and its configuration.
    a_oof_declare: assert property (
        oof_bus.declare
            |=> (!in_frame && r_q.status[`TFIS_BIT_OOF]))
        else $error("declare did not drop frame and set status");

    a_oof_clear: assert property (
        oof_bus.clear
            |=> (in_frame && r_q.status[`TFIS_BIT_OOF]))
        else $error("clear did not restore frame and set status");

    a_oof_cause: assert property (
        oof_bus.declare
            |-> (fbit_valid && fbit_error))
        else $error("out of frame declared without a framing error");

    a_oof_idle: assert property (
        (!fbit_valid && in_frame)
            |=> in_frame)
        else $error("frame lost without a framing bit");

    a_fe_keeps: assert property (
        (fbit_valid && fbit_error && in_frame && !oof_bus.declare)
            |=> in_frame)
        else $error("framing error below threshold dropped frame");

    a_cfg_write: assert property (
        (reg_wr && reg_addr == `TFIS_OFF_OOF_CFG)
            |=> ({r_q.window, r_q.threshold} == $past(reg_wdata)))
        else $error("out of frame settings write lost");

    a_align_read: assert property (
        (reg_rd && reg_addr == `TFIS_OFF_ALIGN)
            |=> (reg_rdata == {7'h00, $past(in_frame)}))
        else $error("alignment read did not return frame state");

    // Enables, robbed-bit control and the interrupt output.
    a_en_keep: assert property (
        !(reg_wr && reg_addr == `TFIS_OFF_ENABLE)
            |=> $stable(r_q.enable))
        else $error("enable changed without a write");

    a_ctrl_write: assert property (
        (reg_wr && reg_addr == `TFIS_OFF_CTRL)
            |=> (rbs_on == $past(reg_wdata[`TFIS_BIT_RBS_EN])))
        else $error("robbed bit control write lost");

    a_irq_off: assert property (
        ((r_q.status & r_q.enable) == 8'h00)
            |-> !irq)
        else $error("interrupt raised with no enabled status");

    a_irq_on: assert property (
        ((r_q.status & r_q.enable & 8'h1f) != 8'h00)
            |-> irq)
        else $error("enabled status raised no interrupt");

    a_irq_sig: assert property (
        (!rbs_on && (r_q.status & r_q.enable & 8'h1f) == 8'h00)
            |-> !irq)
        else $error("signaling enable acted with robbed bit off");

    a_irq_fmd: assert property (
        (r_q.enable[`TFIS_BIT_FMD] && r_q.status[`TFIS_BIT_FMD])
            |-> irq)
        else $error("enabled frame mimic raised no interrupt");

endmodule : tfis_top
`default_nettype wire

// file: pkg/tfis_consts.svh
// Offsets, field positions and reset values of the framer interrupt status and enable logic.
`ifndef TFIS_CONSTS_SVH
`define TFIS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TFIS_ADDR_W          4
`define TFIS_OFF_STATUS      4'h0
`define TFIS_OFF_ENABLE      4'h1
`define TFIS_OFF_OOF_CFG     4'h2
`define TFIS_OFF_SIG_CHG0    4'h3
`define TFIS_OFF_SIG_CHG1    4'h4
`define TFIS_OFF_SIG_CHG2    4'h5
`define TFIS_OFF_CTRL        4'h6
`define TFIS_OFF_ALIGN       4'h7

// ----------------------------------------------------------------------------
// Field positions in status and enable
// ----------------------------------------------------------------------------
`define TFIS_BIT_FE          0
`define TFIS_BIT_SE          1
`define TFIS_BIT_FMD         2
`define TFIS_BIT_OOF         3
`define TFIS_BIT_ALIGNMENT_CHANGE        4
`define TFIS_BIT_SIG         5
`define TFIS_NUM_SRC         6
`define TFIS_NUM_CHAN        24
`define TFIS_BIT_RBS_EN      0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define TFIS_RST_STATUS      8'h00
`define TFIS_RST_ENABLE      8'h00
`define TFIS_RST_THRESH      4'h2
`define TFIS_RST_WINDOW      4'h4
`define TFIS_RST_CTRL        8'h00

`endif

// file: pkg/tfis_pkg.sv
// Types shared by the framer interrupt status and enable logic.
`default_nettype none
package tfis_pkg;

    typedef enum logic {
        TFIS_IN_FRAME,
        TFIS_OUT_OF_FRAME
    } tfis_frame_t;

    typedef struct packed {
        logic [3:0]  err_cnt;
        logic [3:0]  win_cnt;
        tfis_frame_t frame;
    } tfis_oof_state_t;

endpackage : tfis_pkg
`default_nettype wire

// file: pkg/tfis_oof_if.sv
// Interface carrying out-of-frame detector settings and results.
`timescale 1ns/1ps
`default_nettype none
interface tfis_oof_if;
    logic [3:0] error_threshold;
    logic [3:0] error_window;
    logic       in_frame;
    logic       declare;
    logic       clear;

    modport ctl (output error_threshold, output error_window,
                 input in_frame, input declare, input clear);
    modport det (input error_threshold, input error_window,
                 output in_frame, output declare, output clear);
endinterface : tfis_oof_if
`default_nettype wire

// file: core/tfis_oof_detect.sv
// Out-of-frame detector counting framing-bit errors in an observation window.
`timescale 1ns/1ps
`default_nettype none
`include "tfis_consts.svh"
module tfis_oof_detect (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic fbit_valid,
    input  wire logic fbit_error,
    input  wire logic realign,
    tfis_oof_if.det   oof
);
    tfis_pkg::tfis_oof_state_t st_q;
    tfis_pkg::tfis_oof_state_t st_d;
    logic                      decl_hit;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Errors count within a fixed block of framing bits, restarted at each window end; a realign pulse
    // from the aligner is the only way back into frame.
    always_comb begin
        st_d     = st_q;
        decl_hit = 1'b0;
        case (st_q.frame)
            tfis_pkg::TFIS_IN_FRAME: begin
                if (fbit_valid) begin
                    if (fbit_error &&
                        (4'(st_q.err_cnt + 4'h1) >= oof.error_threshold)) begin
                        decl_hit     = 1'b1;
                        st_d.frame   = tfis_pkg::TFIS_OUT_OF_FRAME;
                        st_d.err_cnt = 4'h0;
                        st_d.win_cnt = 4'h0;
                    end else if (4'(st_q.win_cnt + 4'h1) >= oof.error_window) begin
                        st_d.err_cnt = 4'h0;
                        st_d.win_cnt = 4'h0;
                    end else begin
                        st_d.err_cnt = 4'(st_q.err_cnt + {3'h0, fbit_error});
                        st_d.win_cnt = 4'(st_q.win_cnt + 4'h1);
                    end
                end
            end
            default: begin
                if (realign) begin
                    st_d.frame = tfis_pkg::TFIS_IN_FRAME;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '{err_cnt: 4'h0, win_cnt: 4'h0, frame: tfis_pkg::TFIS_IN_FRAME};
        end else begin
            st_q <= st_d;
        end
    end

    assign oof.in_frame = (st_q.frame == tfis_pkg::TFIS_IN_FRAME);
    assign oof.declare  = decl_hit;
    assign oof.clear    = (st_q.frame == tfis_pkg::TFIS_OUT_OF_FRAME) && realign;

endmodule : tfis_oof_detect
`default_nettype wire

// file: verification/tfis_line_model.sv
// Line-side model of the receive framer detection events feeding the block.
`timescale 1ns/1ps
`default_nettype none
module tfis_line_model (
    input  wire logic        clk_sys,
    output logic             fbit_valid,
    output logic             fbit_error,
    output logic             crc6_error,
    output logic             frame_mimic,
    output logic             alignment_change,
    output logic [23:0]      sig_change
);
    // ------------------------
    // Event pulses
    // ------------------------
    // Idle event lines rest low, exactly as a real detector leaves them between events.
    initial begin
        fbit_valid       = 1'b0;
        fbit_error       = 1'b0;
        crc6_error       = 1'b0;
        frame_mimic      = 1'b0;
        alignment_change = 1'b0;
        sig_change       = 24'h000000;
    end

    // One cycle of detector activity; ev bits: valid, error, crc, mimic, align.
    // A framing-bit error is only meaningful with valid, so callers pass both.
    task automatic fire(input logic [4:0] ev, input logic [23:0] chans);
        @(posedge clk_sys);
        fbit_valid       <= ev[0];
        fbit_error       <= ev[1];
        crc6_error       <= ev[2];
        frame_mimic      <= ev[3];
        alignment_change <= ev[4];
        sig_change       <= chans;
        @(posedge clk_sys);
        {fbit_valid, fbit_error, crc6_error, frame_mimic, alignment_change} <= 5'h00;
        sig_change       <= 24'h000000;
    endtask : fire
endmodule : tfis_line_model
`default_nettype wire

// file: verification/test_t1_framer_interrupt_status_enable.sv
// Self-checking testbench of the framer interrupt status and enable logic.
`timescale 1ns/1ps
`default_nettype none
`include "tfis_consts.svh"
module test_t1_framer_interrupt_status_enable;
    logic        clk_sys;
    logic        rst;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        fbit_valid;
    logic        fbit_error;
    logic        crc6_error;
    logic        frame_mimic;
    logic        alignment_change;
    logic [23:0] sig_change;
    logic        in_frame;
    logic        irq;
    int          mismatches;
    int          total_checks;

    // Free-running 25 MHz system clock.
    always #20 clk_sys = ~clk_sys;

    tfis_top dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fbit_valid(fbit_valid),
        .fbit_error(fbit_error), .crc6_error(crc6_error), .frame_mimic(frame_mimic),
        .alignment_change(alignment_change), .sig_change(sig_change), .in_frame(in_frame),
        .irq(irq));

    tfis_line_model model (.clk_sys(clk_sys), .fbit_valid(fbit_valid),
        .fbit_error(fbit_error), .crc6_error(crc6_error), .frame_mimic(frame_mimic),
        .alignment_change(alignment_change), .sig_change(sig_change));

    // ------------------------
    // Checking and bus tasks
    // ------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        if (mismatches == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so they are taken there.
    task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(what, reg_rdata, exp);
    endtask : rdchk

    // Bounded wait on the frame flag; running out ends the run.
    task automatic wait_frame(input logic lvl);
        for (int n = 0; n < 16 && in_frame !== lvl; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("in_frame", {7'h00, in_frame}, {7'h00, lvl});
        if (in_frame !== lvl) begin
            final_report();
        end
    endtask : wait_frame

    // ------------------------
    // Scenarios
    // ------------------------
    task automatic t_reset();
        chk("irq", {7'h00, irq}, 8'h00);
        chk("in_frame", {7'h00, in_frame}, 8'h01);
        rdchk("status", `TFIS_OFF_STATUS, `TFIS_RST_STATUS);
        rdchk("enable", `TFIS_OFF_ENABLE, `TFIS_RST_ENABLE);
        rdchk("oof_cfg", `TFIS_OFF_OOF_CFG, {`TFIS_RST_WINDOW, `TFIS_RST_THRESH});
        for (int a = 8; a < 16; a++) begin
            rdchk("unmapped", a[3:0], 8'h00);
        end
    endtask : t_reset

    task automatic t_regs();
        wr(`TFIS_OFF_ENABLE, 8'hff);
        rdchk("enable", `TFIS_OFF_ENABLE, 8'h3f);
        wr(`TFIS_OFF_ENABLE, 8'h00);
        rdchk("enable", `TFIS_OFF_ENABLE, 8'h00);
        wr(`TFIS_OFF_STATUS, 8'hff);
        rdchk("status", `TFIS_OFF_STATUS, 8'h00);
    endtask : t_regs

    // Status stays sticky while masked; enabling afterwards raises the request.
    task automatic t_sources();
        logic [4:0] ev [4] = '{5'h03, 5'h04, 5'h08, 5'h10};
        int         bt [4] = '{`TFIS_BIT_FE, `TFIS_BIT_SE, `TFIS_BIT_FMD, `TFIS_BIT_ALIGNMENT_CHANGE};
        for (int i = 0; i < 4; i++) begin
            model.fire(ev[i], 24'h000000);
            #1;
            chk("irq masked", {7'h00, irq}, 8'h00);
            wr(`TFIS_OFF_ENABLE, 8'h01 << bt[i]);
            #1;
            chk("irq", {7'h00, irq}, 8'h01);
            chk("in_frame", {7'h00, in_frame}, 8'h01);
            rdchk("status", `TFIS_OFF_STATUS, 8'h01 << bt[i]);
            chk("irq cleared", {7'h00, irq}, 8'h00);
            rdchk("status again", `TFIS_OFF_STATUS, 8'h00);
            wr(`TFIS_OFF_ENABLE, 8'h00);
        end
    endtask : t_sources

    // One framing error on top of the one left by t_sources reaches the threshold; realignment clears the defect.
    task automatic t_oof();
        wr(`TFIS_OFF_ENABLE, 8'h01 << `TFIS_BIT_OOF);
        model.fire(5'h03, 24'h000000);
        model.fire(5'h03, 24'h000000);
        wait_frame(1'b0);
        chk("irq declare", {7'h00, irq}, 8'h01);
        rdchk("status", `TFIS_OFF_STATUS, 8'h09);
        rdchk("align", `TFIS_OFF_ALIGN, 8'h00);
        model.fire(5'h10, 24'h000000);
        wait_frame(1'b1);
        chk("irq clear", {7'h00, irq}, 8'h01);
        rdchk("status", `TFIS_OFF_STATUS, 8'h18);
        rdchk("align", `TFIS_OFF_ALIGN, 8'h01);
        wr(`TFIS_OFF_ENABLE, 8'h00);
    endtask : t_oof

    // Errors spread wider than the window never add up; two inside one do.
    task automatic t_window();
        wr(`TFIS_OFF_OOF_CFG, 8'h22);
        model.fire(5'h03, 24'h000000);
        model.fire(5'h01, 24'h000000);
        model.fire(5'h03, 24'h000000);
        #1;
        chk("in_frame window", {7'h00, in_frame}, 8'h01);
        model.fire(5'h03, 24'h000000);
        wait_frame(1'b0);
        wr(`TFIS_OFF_ENABLE, 8'h01 << `TFIS_BIT_ALIGNMENT_CHANGE);
        model.fire(5'h10, 24'h000000);
        #1;
        chk("irq realign", {7'h00, irq}, 8'h01);
        rdchk("status", `TFIS_OFF_STATUS, 8'h19);
        wr(`TFIS_OFF_ENABLE, 8'h00);
        wr(`TFIS_OFF_OOF_CFG, {`TFIS_RST_WINDOW, `TFIS_RST_THRESH});
    endtask : t_window

    task automatic t_sig();
        wr(`TFIS_OFF_ENABLE, 8'h01 << `TFIS_BIT_SIG);
        model.fire(5'h00, 24'h800201);
        #1;
        chk("irq rbs off", {7'h00, irq}, 8'h00);
        rdchk("status", `TFIS_OFF_STATUS, 8'h00);
        wr(`TFIS_OFF_CTRL, 8'h01);
        model.fire(5'h00, 24'h800201);
        #1;
        chk("irq sig", {7'h00, irq}, 8'h01);
        rdchk("chg0", `TFIS_OFF_SIG_CHG0, 8'h01);
        rdchk("chg1", `TFIS_OFF_SIG_CHG1, 8'h02);
        rdchk("chg2", `TFIS_OFF_SIG_CHG2, 8'h80);
        rdchk("chg0 again", `TFIS_OFF_SIG_CHG0, 8'h00);
        rdchk("status", `TFIS_OFF_STATUS, 8'h20);
        wr(`TFIS_OFF_CTRL, 8'h00);
        wr(`TFIS_OFF_ENABLE, 8'h00);
    endtask : t_sig

    // Reset, then the scenarios in order, then the verdict.
    initial begin
        clk_sys      = 1'b0;
        rst          = 1'b1;
        reg_addr     = 4'h0;
        reg_wdata    = 8'h00;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        mismatches   = 0;
        total_checks = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        t_reset();
        t_regs();
        t_sources();
        t_oof();
        t_window();
        t_sig();
        final_report();
    end
endmodule : test_t1_framer_interrupt_status_enable
`default_nettype wire
